// file: rtl/ptw_pkg.sv
// Package of constants and helpers for the PCI target window 1 block
package ptw_pkg;

  // ****************************************************************
  // Register map (byte addresses on the register bus)
  // ****************************************************************
  localparam int          PTW_ADR_W        = 16;            // Register bus address width
  localparam logic [15:0] PTW_OFS_BASE     = 16'hd188;      // window1_internal_base
  localparam logic [15:0] PTW_OFS_CTRL     = 16'hd18c;      // window1_control

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          PTW_BASE_HI      = 31;            // Base field top bit
  localparam int          PTW_BASE_LO      = 20;            // Base field bottom bit
  localparam int          PTW_MASK_HI      = 28;            // Compare mask top bit
  localparam int          PTW_MASK_LO      = 20;            // Compare mask bottom bit
  localparam int          PTW_LEN_HI       = 10;            // Burst length code top bit
  localparam int          PTW_LEN_LO       = 8;             // Burst length code bottom bit
  localparam int          PTW_FLUSH_BIT    = 4;             // Cache flush bit
  localparam int          PTW_FIXED_BIT    = 3;             // Reserved bit held at its value
  localparam int          PTW_PE_BIT       = 2;             // Prefetch enable bit
  localparam int          PTW_EN_BIT       = 1;             // Window enable bit
  localparam int          PTW_SWAP_BIT     = 0;             // Byte swap bit
  localparam logic [11:0] PTW_BASE_RST     = 12'h000;       // Base reset value
  localparam logic [8:0]  PTW_MASK_RST     = 9'h03f;        // Compare mask reset value
  localparam logic [2:0]  PTW_LEN_RST      = 3'h3;          // Burst length reset code
  localparam logic        PTW_FIXED_VAL    = 1'b1;          // Held value of bit 3
  localparam logic        PTW_PE_RST       = 1'b1;          // Prefetch enable reset
  localparam logic        PTW_EN_RST       = 1'b0;          // Window enable reset
  localparam logic [2:0]  PTW_TOP_ALWAYS   = 3'h7;          // Bits 31:29 always compared

  // ****************************************************************
  // Configuration-space base address register layout
  // ****************************************************************
  localparam logic [3:0]  PTW_BAR_LO_ATTR  = 4'hc;          // Prefetchable, 64-bit, memory
  localparam logic [31:0] PTW_CFG_OFF_VAL  = 32'hffffffff;  // Answer while window disabled
  localparam logic [1:0]  PTW_STRAP_CYC    = 2'h2;          // Cycles until strap is settled

  // Burst length code to words; any code with the top bit set is 32
  function automatic logic [5:0] ptw_len_words(input logic [2:0] code);
    logic [5:0] w;
    w = 6'h20;
    if (!code[2])
    begin
      unique case (code[1:0])
        2'h0: w = 6'h01;
        2'h1: w = 6'h04;
        2'h2: w = 6'h08;
        2'h3: w = 6'h10;
      endcase
    end
    return w;
  endfunction

endpackage

// file: rtl/ptw_sync.sv
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module ptw_sync
  import ptw_pkg::*;
(
  input  wire logic clk,      // System clock
  input  wire logic rst,      // Asynchronous reset, active high
  input  wire logic async_i,  // Level from a pin
  output logic      sync_o    // Level safe to use on clk
);

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  logic meta_q;  // First stage, read only by the second

  // Two flops; metastability settles in the first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// file: rtl/ptw_burst.sv
// Internal-bus read burst issuer with optional one-burst prefetch
`timescale 1ns/1ps
module ptw_burst
  import ptw_pkg::*;
(
  input  wire logic        clk,         // System clock
  input  wire logic        rst,         // Asynchronous reset, active high
  input  wire logic        start_i,     // Target read hit, one-cycle pulse
  input  wire logic [31:0] addr_i,      // Internal-bus start address
  input  wire logic [2:0]  len_code_i,  // Burst length code
  input  wire logic        pe_i,        // Prefetch enable
  input  wire logic        flush_i,     // Cache flush, drops a pending prefetch
  input  wire logic        ack_i,       // Internal bus accepted the burst
  output logic             req_q,       // Burst request, held until ack
  output logic [31:0]      addr_q,      // Burst address
  output logic [5:0]       len_q        // Burst length in words
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {PTW_IDLE, PTW_DEMAND, PTW_PREFETCH} ptw_bst_t;
  ptw_bst_t   state_q;  // Current phase
  ptw_bst_t   state_d;  // Next phase
  logic [31:0] next_addr;  // Address following the current burst
  logic        go_pref;    // Follow demand burst with a prefetch

  assign next_addr = addr_q + {24'h0, len_q, 2'b00};
  assign go_pref   = pe_i && !flush_i;

  // Phase selection; a read hit that arrives outside PTW_IDLE is dropped, not queued
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PTW_IDLE:     if (start_i) state_d = PTW_DEMAND;
      PTW_DEMAND:   if (ack_i) state_d = go_pref ? PTW_PREFETCH : PTW_IDLE;
      PTW_PREFETCH: if (ack_i || flush_i) state_d = PTW_IDLE;
    endcase
  end

  // Request register; only one prefetch burst so the read cache stays bounded
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= PTW_IDLE;
      req_q   <= 1'b0;
      addr_q  <= 32'h0;
      len_q   <= 6'h01;
    end
    else
    begin
      state_q <= state_d;
      req_q   <= (state_d != PTW_IDLE);
      if (state_q == PTW_IDLE && start_i)
      begin
        addr_q <= addr_i;
        len_q  <= ptw_len_words(len_code_i);
      end
      else if (state_q == PTW_DEMAND && state_d == PTW_PREFETCH)
        addr_q <= next_addr;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_single_burst: assert property (@(posedge clk) disable iff (rst)
    (state_q == PTW_DEMAND && ack_i && !pe_i && !start_i) |=> !req_q)
    else $error("Extra burst issued with prefetch off");

  a_prefetch_follow: assert property (@(posedge clk) disable iff (rst)
    (state_q == PTW_DEMAND && ack_i && pe_i && !flush_i)
      |=> req_q && addr_q == $past(next_addr))
    else $error("Prefetch burst missing or misplaced");

endmodule

// file: rtl/ptw_window.sv
// Inbound PCI target memory window 1: registers, hit logic and bursts
`timescale 1ns/1ps

module ptw_window
  import ptw_pkg::*;
(
  input  wire logic                 clk,           // System clock, 50 MHz
  input  wire logic                 rst,           // Asynchronous reset, active high
  input  wire logic [PTW_ADR_W-1:0] wb_adr_i,      // Wishbone byte address
  input  wire logic [31:0]          wb_dat_i,      // Wishbone write data
  input  wire logic [3:0]           wb_sel_i,      // Wishbone byte selects
  input  wire logic                 wb_we_i,       // Wishbone write enable
  input  wire logic                 wb_cyc_i,      // Wishbone cycle
  input  wire logic                 wb_stb_i,      // Wishbone strobe
  output logic [31:0]               wb_dat_o,      // Wishbone read data
  output logic                      wb_ack_o,      // Wishbone acknowledge
  input  wire logic                 big_endian_i,  // Endian strap pin
  input  wire logic                 tgt_valid,     // PCI memory access present
  input  wire logic                 tgt_write,     // Access is a write
  input  wire logic [31:0]          tgt_addr,      // PCI address
  input  wire logic [31:0]          tgt_wdata,     // PCI write data
  output logic                      tgt_hit_q,     // Access hit window 1
  output logic [31:0]               ib_addr_q,     // Translated internal address
  output logic                      ib_wr_q,       // Internal write strobe
  output logic [31:0]               ib_wdata_q,    // Internal write data
  input  wire logic                 ib_rd_ack,     // Internal bus took the burst
  output logic                      ib_rd_req_q,   // Internal read burst request
  output logic [31:0]               ib_rd_addr_q,  // Burst address
  output logic [5:0]                ib_rd_len_q,   // Burst length in words
  input  wire logic                 ib_rvalid,     // Internal read data valid
  input  wire logic [31:0]          ib_rdata,      // Internal read data
  output logic                      tgt_rvalid_q,  // Read data to PCI valid
  output logic [31:0]               tgt_rdata_q,   // Read data to PCI
  output logic                      cache_flush_q, // Read cache invalidate pulse
  input  wire logic                 cfg_bar_wr,    // Config write to a window BAR
  input  wire logic                 cfg_bar_rd,    // Config read of a window BAR
  input  wire logic                 cfg_bar_upper, // Selects the upper BAR
  input  wire logic [31:0]          cfg_wdata,     // Config write data
  output logic [31:0]               cfg_rdata_q    // Config read data
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [11:0] base_q;      // Internal-bus window base
  logic [8:0]  mask_q;      // Address compare mask
  logic [2:0]  len_code_q;  // Burst length code
  logic        flush_q;     // Cache flush, self clearing
  logic        pe_q;        // Window prefetch enable
  logic        en_q;        // Window enable
  logic        swap_q;      // Byte swap enable
  logic [11:0] bar_lo_q;    // PCI BAR lower, bits 31:20
  logic [31:0] bar_hi_q;    // PCI BAR upper
  logic [1:0]  init_cnt_q;  // Counts to strap settle point
  logic        strap_be;    // Synchronised endian strap

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  wire        wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;  // New request
  wire        wb_xfer   = wb_cyc_i && wb_stb_i && wb_ack_o;   // Transfer ends at ack edge
  wire        hit_base  = (wb_adr_i == PTW_OFS_BASE);         // Base register hit
  wire        hit_ctrl  = (wb_adr_i == PTW_OFS_CTRL);         // Control register hit
  // Writes land at the edge where the master sees ack, as the bus defines it
  wire        wr_base   = wb_xfer && wb_we_i && hit_base;     // Base write
  wire        wr_ctrl   = wb_xfer && wb_we_i && hit_ctrl;     // Control write
  wire [31:0] be_mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}; // Byte lane mask

  // Register images as seen by software, reserved bits zero except bit 3, held at one
  wire [31:0] base_img  = {base_q, 20'h0};
  wire [31:0] ctrl_img  = {3'h0, mask_q, 9'h0, len_code_q, 3'h0, flush_q,
                           PTW_FIXED_VAL, pe_q, en_q, swap_q};
  wire [31:0] base_new  = (base_img & ~be_mask) | (wb_dat_i & be_mask);  // Merged base
  wire [31:0] ctrl_new  = (ctrl_img & ~be_mask) | (wb_dat_i & be_mask);  // Merged control

  // Read mux; unmapped addresses answer with zero
  wire [31:0] rd_mux    = hit_base ? base_img :
                          hit_ctrl ? ctrl_img : 32'h0;

  // Wishbone answer: ack one cycle after the request, dropped the next
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0;
    end
  end

  // ****************************************************************
  // Endian strap capture
  // ****************************************************************
  ptw_sync u_strap_sync (
    .clk     (clk),
    .rst     (rst),
    .async_i (big_endian_i),
    .sync_o  (strap_be)
  );

  // Settle counter; the strap is taken only after the synchroniser is valid
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      init_cnt_q <= 2'h0;
    else if (init_cnt_q != PTW_STRAP_CYC + 2'h1)
      init_cnt_q <= init_cnt_q + 2'h1;
  end

  // One-shot load; the synchroniser output carries the pin only after two edges
  wire strap_load = (init_cnt_q == PTW_STRAP_CYC);  // Strap settled

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Base register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      base_q <= PTW_BASE_RST;
    else if (wr_base)
      base_q <= base_new[PTW_BASE_HI:PTW_BASE_LO];
  end

  // Control register fields
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mask_q     <= PTW_MASK_RST;
      len_code_q <= PTW_LEN_RST;
      pe_q       <= PTW_PE_RST;
      en_q       <= PTW_EN_RST;
    end
    else if (wr_ctrl)
    begin
      mask_q     <= ctrl_new[PTW_MASK_HI:PTW_MASK_LO];
      len_code_q <= ctrl_new[PTW_LEN_HI:PTW_LEN_LO];
      pe_q       <= ctrl_new[PTW_PE_BIT];
      en_q       <= ctrl_new[PTW_EN_BIT];
    end
  end

  // Flush bit: a one sets it, a zero does nothing, it clears the next cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flush_q <= 1'b0;
    else
      flush_q <= wr_ctrl && wb_sel_i[0] && wb_dat_i[PTW_FLUSH_BIT];
  end

  // Swap bit: strap gives the default, software may override afterwards
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      swap_q <= 1'b0;
    else if (strap_load)
      swap_q <= strap_be;
    else if (wr_ctrl)
      swap_q <= ctrl_new[PTW_SWAP_BIT];
  end

  // ****************************************************************
  // Configuration-space base address registers
  // ****************************************************************
  // Writes land only while the window is enabled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bar_lo_q <= PTW_BASE_RST;
      bar_hi_q <= 32'h0;
    end
    else if (cfg_bar_wr && en_q)
    begin
      if (cfg_bar_upper)
        bar_hi_q <= cfg_wdata;
      else
        bar_lo_q <= cfg_wdata[PTW_BASE_HI:PTW_BASE_LO];
    end
  end

  // Prefetchable flag is a constant; the prefetch enable never reaches it
  wire [31:0] bar_lo_img = {bar_lo_q, 16'h0, PTW_BAR_LO_ATTR};
  wire [31:0] cfg_mux    = !en_q         ? PTW_CFG_OFF_VAL :
                           cfg_bar_upper ? bar_hi_q : bar_lo_img;

  // Config read data register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cfg_rdata_q <= 32'h0;
    else if (cfg_bar_rd)
      cfg_rdata_q <= cfg_mux;
  end

  // ****************************************************************
  // Address compare and translation
  // ****************************************************************
  wire [11:0] cmp_mask  = {PTW_TOP_ALWAYS, mask_q};
  wire        addr_hit  = ((tgt_addr[31:20] ^ bar_lo_q) & cmp_mask) == 12'h0;
  wire        win_hit   = tgt_valid && en_q && addr_hit;
  wire [31:0] xlat_addr = {(base_q & cmp_mask) | (tgt_addr[31:20] & ~cmp_mask),
                           tgt_addr[19:0]};
  wire        rd_start  = win_hit && !tgt_write;                      // Read hit

  // Byte swap; unswapped words pass as they are in either endian mode
  function automatic logic [31:0] swap32(input logic [31:0] d, input logic s);
    return s ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction

  // Target write path and hit flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tgt_hit_q  <= 1'b0;
      ib_addr_q  <= 32'h0;
      ib_wr_q    <= 1'b0;
      ib_wdata_q <= 32'h0;
    end
    else
    begin
      tgt_hit_q <= win_hit;
      ib_wr_q   <= win_hit && tgt_write;
      if (win_hit)
      begin
        ib_addr_q  <= xlat_addr;
        ib_wdata_q <= swap32(tgt_wdata, swap_q);
      end
    end
  end

  // Read return path, swapped the same way
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tgt_rvalid_q <= 1'b0;
      tgt_rdata_q  <= 32'h0;
    end
    else
    begin
      tgt_rvalid_q <= ib_rvalid;
      tgt_rdata_q  <= swap32(ib_rdata, swap_q);
    end
  end

  // Flush pulse to the read cache, one cycle after flush_q; flush_q itself cancels a pending prefetch
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cache_flush_q <= 1'b0;
    else
      cache_flush_q <= flush_q;
  end

  // ****************************************************************
  // Read burst issue
  // ****************************************************************
  // Satellite-mode prefetch advice is left to software; hardware obeys pe_q
  ptw_burst u_burst (
    .clk        (clk),
    .rst        (rst),
    .start_i    (rd_start),
    .addr_i     (xlat_addr),
    .len_code_i (len_code_q),
    .pe_i       (pe_q),
    .flush_i    (flush_q),
    .ack_i      (ib_rd_ack),
    .req_q      (ib_rd_req_q),
    .addr_q     (ib_rd_addr_q),
    .len_q      (ib_rd_len_q)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_flush_write;
    wr_ctrl && wb_sel_i[0] && wb_dat_i[PTW_FLUSH_BIT];
  endsequence

  sequence s_flush_pulse;
    flush_q ##1 (!flush_q && cache_flush_q) ##1 !cache_flush_q;
  endsequence

  a_flush_self_clear: assert property (@(posedge clk) disable iff (rst)
    s_flush_write |=> s_flush_pulse)
    else $error("Flush bit not a single self-clearing pulse");

  a_ack_single: assert property (@(posedge clk) disable iff (rst)
    wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Ack not exactly one cycle after request");

  a_bar_write_blocked: assert property (@(posedge clk) disable iff (rst)
    (cfg_bar_wr && !en_q) |=> $stable(bar_lo_q) && $stable(bar_hi_q))
    else $error("BAR changed while window disabled");

  a_cfg_read_ones: assert property (@(posedge clk) disable iff (rst)
    (cfg_bar_rd && !en_q) |=> cfg_rdata_q == PTW_CFG_OFF_VAL)
    else $error("Disabled BAR read not all ones");

  a_bar_prefetch_flag: assert property (@(posedge clk) disable iff (rst)
    (cfg_bar_rd && en_q && !cfg_bar_upper) |=> cfg_rdata_q[3:0] == PTW_BAR_LO_ATTR)
    else $error("BAR attribute bits moved");

  a_no_hit_disabled: assert property (@(posedge clk) disable iff (rst)
    (tgt_valid && !en_q) |=> !tgt_hit_q && !ib_wr_q)
    else $error("Hit reported on disabled window");

  a_write_swap: assert property (@(posedge clk) disable iff (rst)
    (win_hit && tgt_write) |=>
      ib_wdata_q == ($past(swap_q) ? {$past(tgt_wdata[7:0]), $past(tgt_wdata[15:8]),
                      $past(tgt_wdata[23:16]), $past(tgt_wdata[31:24])} : $past(tgt_wdata)))
    else $error("Write data byte order wrong");

  a_burst_len_map: assert property (@(posedge clk) disable iff (rst)
    (rd_start && !ib_rd_req_q) |=>
      ib_rd_len_q == ptw_len_words($past(len_code_q)) && ib_rd_req_q)
    else $error("Burst length does not follow code");

  a_xlat_base: assert property (@(posedge clk) disable iff (rst)
    win_hit |=> ib_addr_q[19:0] == $past(tgt_addr[19:0]) &&
      ((ib_addr_q[31:20] ^ $past(base_q)) & $past(cmp_mask)) == 12'h0)
    else $error("Translated address ignores base");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (wb_req && !wb_we_i && hit_ctrl) |=> wb_dat_o[31:29] == 3'h0 &&
      wb_dat_o[19:11] == 9'h0 && wb_dat_o[7:5] == 3'h0 && wb_dat_o[3])
    else $error("Reserved control bits wrong");

endmodule

// file: bench/ptw_far_model.sv
// Internal-bus responder that accepts read bursts after a delay
`timescale 1ns/1ps
module ptw_far_model
#(
  parameter int DLY = 2  // One less than the request cycles before a burst is accepted
)
(
  input  wire logic        clk,        // System clock
  input  wire logic        rst,        // Asynchronous reset
  input  wire logic        req,        // Burst request from the window
  input  wire logic [31:0] addr,       // Burst address
  input  wire logic [5:0]  len,        // Burst length in words
  output logic             ack,        // Burst accepted
  output logic             rvalid,     // Read data valid
  output logic [31:0]      rdata,      // Read data
  output int               burst_cnt,  // Bursts accepted so far
  output logic [31:0]      last_addr,  // Address of the last burst
  output logic [5:0]       last_len    // Length of the last burst
);
  int wait_q;  // Cycles the current request has waited
  // Accept after DLY+1 request cycles; record what was held at the accept edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {ack, last_addr, last_len} <= 39'h0;
      burst_cnt <= 0;
      wait_q <= 0;
    end
    else if (ack)
    begin
      ack <= 1'b0;
      burst_cnt <= burst_cnt + 1;
      {last_addr, last_len} <= {addr, len};
      wait_q <= 0;
    end
    else if (req)
    begin
      wait_q <= wait_q + 1;
      ack <= (wait_q == DLY);
    end
  end
  // Data is never left static, so a late sampler cannot see a stale word
  always_ff @(posedge clk)
  begin
    rvalid <= ack;
    rdata <= ack ? 32'h11223344 : ~rdata;
  end
endmodule

// file: bench/testbench.sv
// Self-checking testbench for the target window 1 block
`timescale 1ns/1ps
module testbench
  import ptw_pkg::*;
;
  logic clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, tgt_valid, tgt_write, tgt_hit_q;
  logic ib_wr_q, ib_rd_ack, ib_rd_req_q, ib_rvalid, tgt_rvalid_q, cache_flush_q;
  logic cfg_bar_wr, cfg_bar_rd, cfg_bar_upper, big_endian_i;
  logic [15:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [5:0]  ib_rd_len_q;
  logic [31:0] wb_dat_i, wb_dat_o, tgt_addr, tgt_wdata, ib_addr_q, ib_wdata_q, ib_rd_addr_q;
  logic [31:0] ib_rdata, tgt_rdata_q, cfg_wdata, cfg_rdata_q, q, rd_seen;
  logic [5:0]  lens [5] = '{6'h01, 6'h04, 6'h08, 6'h10, 6'h20};  // Words per code
  int          err_total, compares, fl_cnt, n0;
  ptw_window i_dut (.clk, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .big_endian_i, .tgt_valid, .tgt_write, .tgt_addr,
    .tgt_wdata, .tgt_hit_q, .ib_addr_q, .ib_wr_q, .ib_wdata_q, .ib_rd_ack, .ib_rd_req_q,
    .ib_rd_addr_q, .ib_rd_len_q, .ib_rvalid, .ib_rdata, .tgt_rvalid_q, .tgt_rdata_q,
    .cache_flush_q, .cfg_bar_wr, .cfg_bar_rd, .cfg_bar_upper, .cfg_wdata, .cfg_rdata_q);
  ptw_far_model #(.DLY(2)) i_far (.clk, .rst, .req(ib_rd_req_q), .addr(ib_rd_addr_q),
    .len(ib_rd_len_q), .ack(ib_rd_ack), .rvalid(ib_rvalid), .rdata(ib_rdata),
    .burst_cnt(), .last_addr(), .last_len());
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Count invalidate pulses seen on the cache port
  always @(posedge clk) if (cache_flush_q === 1'b1) fl_cnt++;
  // Keep the last word returned towards the PCI side
  always @(posedge clk) if (tgt_rvalid_q === 1'b1) rd_seen <= tgt_rdata_q;
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic single Wishbone cycle; read data lands in q
  task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hf};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    // Data is taken at the ack edge and the request released right after it
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (wb_ack_o !== 1'b1) err_total++;
  endtask
  // Window control word: full mask, enabled, swapped
  task ctl(input logic [2:0] c, input logic p);
    wb(1'b1, PTW_OFS_CTRL, {12'h1ff, 9'h0, c, 5'h0, p, 2'h3});
  endtask
  // One configuration access of a base address register
  task cfg(input logic w, input logic u, input logic [31:0] d);
    @(posedge clk);
    {cfg_bar_wr, cfg_bar_rd, cfg_bar_upper, cfg_wdata} <= {w, !w, u, d};
    @(posedge clk);
    {cfg_bar_wr, cfg_bar_rd} <= 2'b00;
    #1;
  endtask
  // One PCI memory access cycle
  task tgt(input logic w, input logic [31:0] a);
    @(posedge clk);
    {tgt_valid, tgt_write, tgt_addr, tgt_wdata} <= {1'b1, w, a, 32'h11223344};
    @(posedge clk);
    tgt_valid <= 1'b0;
    #1;
  endtask
  task test_done;
    $display("Mismatches %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog sized well above the expected run length
  initial
  begin
    #400000;
    err_total++;
    test_done;
  end
  initial
  begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, tgt_valid, tgt_write, big_endian_i} = 7'h01 << 6;
    {cfg_bar_wr, cfg_bar_rd, cfg_bar_upper, wb_adr_i, wb_sel_i} = 23'h0;
    {wb_dat_i, tgt_addr, tgt_wdata, cfg_wdata} = 128'h0;
    {err_total, compares, fl_cnt} = 96'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b0, PTW_OFS_BASE, 32'h0); chk(q, 32'h0);
    wb(1'b0, PTW_OFS_CTRL, 32'h0); chk(q, 32'h03f0030c);
    wb(1'b0, 16'h0000, 32'h0); chk(q, 32'h0);
    cfg(1'b1, 1'b0, 32'h55500000); cfg(1'b0, 1'b0, 32'h0); chk(cfg_rdata_q, 32'hffffffff);
    cfg(1'b0, 1'b1, 32'h0); chk(cfg_rdata_q, 32'hffffffff);
    tgt(1'b1, 32'h00045678); chk({31'h0, tgt_hit_q}, 32'h0);
    wb(1'b1, PTW_OFS_CTRL, '1); wb(1'b0, PTW_OFS_CTRL, 32'h0); chk(q, 32'h1ff0070f);
    chk(32'(fl_cnt), 32'h1);
    wb(1'b1, PTW_OFS_BASE, 32'habcfffff); wb(1'b0, PTW_OFS_BASE, 32'h0); chk(q, 32'habc00000);
    cfg(1'b0, 1'b0, 32'h0); chk(cfg_rdata_q, 32'h0000000c);
    cfg(1'b1, 1'b0, 32'h12300000); cfg(1'b0, 1'b0, 32'h0); chk(cfg_rdata_q, 32'h1230000c);
    tgt(1'b1, 32'h12345678); chk({tgt_hit_q, ib_wr_q, ib_addr_q}, {2'b11, 32'habc45678});
    chk(ib_wdata_q, 32'h44332211);
    tgt(1'b1, 32'h22345678); chk({31'h0, tgt_hit_q}, 32'h0);
    // Not in satellite mode, so prefetch may be turned off here
    for (int c = 0; c < 5; c++)
    begin
      ctl(3'(c), 1'b0);
      n0 = i_far.burst_cnt;
      tgt(1'b0, 32'h12300100);
      for (int n = 0; n < 40 && ib_rd_req_q !== 1'b1; n++) @(posedge clk) #1;
      chk({ib_rd_len_q, ib_rd_addr_q}, {lens[c], 32'habc00100});
      repeat (10) @(posedge clk);
      chk({ib_rd_req_q, 32'(i_far.burst_cnt - n0)}, 33'h1);
    end
    cfg(1'b0, 1'b0, 32'h0); chk(cfg_rdata_q, 32'h1230000c);
    ctl(3'h1, 1'b1);
    n0 = i_far.burst_cnt;
    tgt(1'b0, 32'h12300100);
    repeat (20) @(posedge clk);
    chk(32'(i_far.burst_cnt - n0), 32'h2);
    chk(i_far.last_addr, 32'habc00110);
    chk(rd_seen, 32'h44332211);
    // Second reset with the big-endian strap: swap defaults to one
    big_endian_i <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b0, PTW_OFS_CTRL, 32'h0);
    chk(q, 32'h03f0030d);
    wb(1'b1, PTW_OFS_CTRL, 32'h03f00306);
    tgt(1'b1, 32'h00045678);
    chk({tgt_hit_q, ib_wdata_q}, {1'b1, 32'h11223344});
    test_done;
  end
endmodule
